//--- multifunction_timer.sv
// multifunction timer core: counters, hold registers, pwm and register port
// Notes on behaviour
// - two 16-bit down counters, independent except in pulse train mode, where counter two counts counter one underflows
// - hold a and b reload or capture
// - 8-bit programmable prescaler of system clock
// - per-counter clock select, including no-clock stop
// - pins a, b with edge select; a drives pwm
// - one interrupt line per counter
// - modes 1, 1a, 2, 3, 4 supported
// - mode 2 captures counter one on pin events
// - mode 3: a reloads first, b second
// - mode 4: a reloads, b captures
// - mode 1 counts down from software preload
// - underflow reloads alternately a then b
// - every restart takes first reload from a
// - underflow toggles pwm pin, no software needed
// - start level bit picks phase polarity
// - reload a sets pending a; reload b sets pending b only in mode 1
// - second counter underflow interrupt needs enable
// - mode field in main control register
// - pin select fields pick io in modes 2,4
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "mft_cfg.svh"
module multifunction_timer
  import timer_pkg::*;
#(
  parameter int CNT_W       = 16,
  parameter int PRE_W       = 8,
  parameter int IO_N        = 15,
  parameter int DATA_W      = 32,
  parameter int TIMER_INDEX = 0
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [7:0]        addr,
  input  wire logic [DATA_W-1:0] wdata,
  input  wire logic              wr_strobe,
  input  wire logic              rd_strobe,
  output logic      [DATA_W-1:0] rdata,
  input  wire logic [IO_N-1:0]   io_in,
  input  wire logic              timer_pin_a_in,
  output logic                   timer_pin_a_out,
  output logic                   timer_pin_a_oe,
  input  wire logic              timer_pin_b_in,
  output logic                   irq_first,
  output logic                   irq_second
);
  localparam int SEL_A_LO = TIMER_INDEX * 2 * `SEL_FIELD_W;
  localparam int SEL_B_LO = SEL_A_LO + `SEL_FIELD_W;

  logic [`CTL_W-1:0]  ctrl_r;
  logic [PRE_W-1:0]   prescale_r;
  logic [CNT_W-1:0]   cnt1_r;
  logic [CNT_W-1:0]   cnt2_r;
  logic [CNT_W-1:0]   hold_a_r;
  logic [CNT_W-1:0]   hold_b_r;
  logic [`PND_W-1:0]  ien_r;
  logic [`PND_W-1:0]  pend_r;
  logic [`PND_W-1:0]  pend_nxt;
  logic [DATA_W-1:0]  sel_r;
  logic [DATA_W-1:0]  rdata_r;
  phase_t             phase_r;
  mode_t              mode;
  mode_t              mode_prev_r;
  ckc_t               ckc1;
  ckc_t               ckc2;
  logic               pwm_r;
  logic               pwm_oe_r;
  logic               pt_done_r;
  logic               en;
  logic               start_lvl;
  logic               pulse_train;
  logic               pwm_mode;
  logic               restart;
  logic               tick1;
  logic               tick2;
  logic               uf1;
  logic               uf2;
  logic               pwm_a_ev;
  logic               pwm_b_ev;
  logic               reload_a_ev;
  logic               cap_a;
  logic               cap_b;
  logic               preset_ev;
  logic               pin_a_src;
  logic               pin_b_src;
  logic               capture_mode;
  logic               wr_ctrl;
  logic               wr_cnt1;
  logic               wr_cnt2;
  timer_tick_if       tk ();

  // pick one io by its select code; codes past the last io read low
  function automatic logic pick_io(input logic [IO_N-1:0] io, input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < IO_N; i++) begin
      if (code == 8'(i)) begin
        r = io[i];
      end
    end
    return r;
  endfunction

  // clock source choice, shared by both counters
  function automatic logic clk_tick(input ckc_t sel, input logic pre, input logic bev,
                                    input logic blvl);
    logic t;
    t = 1'b0;
    case (sel)
      CKC_PRESCALE:  t = pre;
      CKC_EXT_EVENT: t = bev;
      CKC_PULSE_ACC: t = pre && blvl;
      default:       t = 1'b0;
    endcase
    return t;
  endfunction

  // control field decode
  assign mode        = mode_t'(ctrl_r[`CTL_MODE_HI:`CTL_MODE_LO]);
  assign en          = ctrl_r[`CTL_ENABLE];
  assign start_lvl   = ctrl_r[`CTL_START_LVL];
  assign ckc1        = ckc_t'(ctrl_r[`CTL_CKC1_HI:`CTL_CKC1_LO]);
  assign ckc2        = ckc_t'(ctrl_r[`CTL_CKC2_HI:`CTL_CKC2_LO]);
  assign pulse_train = (mode == MODE_PWM) && ctrl_r[`CTL_PULSE_TRAIN];
  assign pwm_mode    = en && (mode == MODE_PWM);
  assign wr_ctrl     = wr_strobe && (addr == `OFS_CONTROL);
  assign wr_cnt1     = wr_strobe && (addr == `OFS_FIRST_CNT);
  assign wr_cnt2     = wr_strobe && (addr == `OFS_SECOND_CNT);

  // io routing applies only to the capture modes
  assign capture_mode = (mode == MODE_CAPTURE2) || (mode == MODE_CAPTURE1);
  assign pin_a_src = capture_mode ? pick_io(io_in, sel_r[SEL_A_LO +: `SEL_FIELD_W])
                                  : timer_pin_a_in;
  assign pin_b_src = capture_mode ? pick_io(io_in, sel_r[SEL_B_LO +: `SEL_FIELD_W])
                                  : timer_pin_b_in;

  clock_prescaler #(
    .PRE_W (PRE_W)
  ) u_prescaler (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .run     (en),
    .divide  (prescale_r),
    .tk      (tk.prescaler)
  );

  pin_edge_detector u_edges (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pin_a   (pin_a_src),
    .pin_b   (pin_b_src),
    .a_rise  (ctrl_r[`CTL_A_RISE]),
    .b_rise  (ctrl_r[`CTL_B_RISE]),
    .ev      (tk.edges)
  );

  // counter ticks; mode 2 cannot clock counter one from pin b
  always_comb begin
    tick1 = en && clk_tick(ckc1, tk.prescale_tick, tk.b_event, tk.b_level);
    if (mode == MODE_CAPTURE2 && (ckc1 == CKC_EXT_EVENT || ckc1 == CKC_PULSE_ACC)) begin
      tick1 = 1'b0;
    end
    if (pulse_train && pt_done_r) begin
      tick1 = 1'b0;
    end
    uf1 = tick1 && (cnt1_r == '0);
    if (pulse_train) begin
      tick2 = en && uf1;
    end else begin
      tick2 = en && clk_tick(ckc2, tk.prescale_tick, tk.b_event, tk.b_level);
    end
    uf2 = tick2 && (cnt2_r == '0);
  end

  // restart conditions send the reload sequence back to register a
  assign restart  = !pwm_mode || (ckc1 == CKC_NONE) || (mode_prev_r != MODE_PWM);
  assign pwm_a_ev = pwm_mode && uf1 && !restart && (phase_r != PH_A);
  assign pwm_b_ev = pwm_mode && uf1 && !restart && (phase_r == PH_A);
  assign reload_a_ev = pwm_a_ev ||
                       (en && uf1 && (mode == MODE_DUAL || mode == MODE_CAPTURE1));
  assign cap_a     = en && (mode == MODE_CAPTURE2) && tk.a_event;
  assign cap_b     = en && capture_mode && tk.b_event;
  assign preset_ev = (cap_a && ctrl_r[`CTL_A_PRESET]) || (cap_b && ctrl_r[`CTL_B_PRESET]);

  // software visible configuration registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_r     <= `RST_CTRL;
      prescale_r <= `RST_PRESCALE;
      ien_r      <= '0;
      sel_r      <= `RST_PIN_SELECT;
    end else if (wr_strobe) begin
      case (addr)
        `OFS_CONTROL:    ctrl_r     <= wdata[`CTL_W-1:0];
        `OFS_PRESCALE:   prescale_r <= wdata[PRE_W-1:0];
        `OFS_IRQ_ENABLE: ien_r      <= wdata[`PND_W-1:0];
        `OFS_PIN_SELECT: sel_r      <= wdata;
        default: ;
      endcase
    end
  end

  // first counter: software preload wins, then preset, reload, count
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt1_r <= '0;
    end else if (wr_cnt1) begin
      cnt1_r <= wdata[CNT_W-1:0];
    end else if (preset_ev) begin
      cnt1_r <= '1;
    end else if (uf1) begin
      case (mode)
        MODE_PWM:      cnt1_r <= (phase_r == PH_A) ? hold_b_r : hold_a_r;
        MODE_DUAL:     cnt1_r <= hold_a_r;
        MODE_CAPTURE1: cnt1_r <= hold_a_r;
        default:       cnt1_r <= '1;
      endcase
    end else if (tick1) begin
      cnt1_r <= cnt1_r - 1'b1;
    end
  end

  // second counter; pulse train stops at zero instead of wrapping
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt2_r <= '0;
    end else if (wr_cnt2) begin
      cnt2_r <= wdata[CNT_W-1:0];
    end else if (uf2) begin
      if (pulse_train) begin
        cnt2_r <= '0;
      end else if (mode == MODE_DUAL) begin
        cnt2_r <= hold_b_r;
      end else begin
        cnt2_r <= '1;
      end
    end else if (tick2) begin
      cnt2_r <= cnt2_r - 1'b1;
    end
  end

  // pulse train end gates counter one until software reloads counter two
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !pulse_train || wr_cnt2) begin
      pt_done_r <= 1'b0;
    end else if (uf2) begin
      pt_done_r <= 1'b1;
    end
  end

  // hold registers; a capture beats a same-cycle software write
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hold_a_r <= '0;
      hold_b_r <= '0;
    end else begin
      if (cap_a) begin
        hold_a_r <= cnt1_r;
      end else if (wr_strobe && addr == `OFS_HOLD_A) begin
        hold_a_r <= wdata[CNT_W-1:0];
      end
      if (cap_b) begin
        hold_b_r <= cnt1_r;
      end else if (wr_strobe && addr == `OFS_HOLD_B) begin
        hold_b_r <= wdata[CNT_W-1:0];
      end
    end
  end

  // reload phase sequencer
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_r     <= PH_IDLE;
      mode_prev_r <= MODE_PWM;
    end else begin
      mode_prev_r <= en ? mode : MODE_CAPTURE2;
      if (restart) begin
        phase_r <= PH_IDLE;
      end else if (pwm_a_ev) begin
        phase_r <= PH_A;
      end else if (pwm_b_ev) begin
        phase_r <= PH_B;
      end else if (phase_r == PH_IDLE) begin
        phase_r <= PH_LEAD;
      end
    end
  end

  // pwm pin: a phase at the start level, b phase and lead-in opposite
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_r    <= 1'b1;
      pwm_oe_r <= 1'b0;
    end else begin
      pwm_oe_r <= en && (mode == MODE_PWM || mode == MODE_DUAL);
      if (pwm_mode) begin
        if (restart) begin
          pwm_r <= !start_lvl;
        end else if (pwm_a_ev) begin
          pwm_r <= start_lvl;
        end else if (pwm_b_ev) begin
          pwm_r <= !start_lvl;
        end
      end else if (en && mode == MODE_DUAL) begin
        if (uf1) begin
          pwm_r <= !pwm_r; // 50 percent clock in dual timer mode
        end
      end else begin
        pwm_r <= !start_lvl;
      end
    end
  end

  // pending flags: a hardware set wins over a write-one clear
  always_comb begin
    pend_nxt = pend_r;
    if (wr_strobe && addr == `OFS_PENDING) begin
      pend_nxt = pend_r & ~wdata[`PND_W-1:0];
    end
    pend_nxt[`PND_A]   = pend_nxt[`PND_A] || reload_a_ev || cap_a;
    pend_nxt[`PND_B]   = pend_nxt[`PND_B] || pwm_b_ev || cap_b;
    pend_nxt[`PND_UF1] = pend_nxt[`PND_UF1] || (uf1 && mode == MODE_CAPTURE2);
    pend_nxt[`PND_UF2] = pend_nxt[`PND_UF2] || uf2;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // read data stand for exactly one cycle, zero otherwise and for holes
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !rd_strobe) begin
      rdata_r <= '0;
    end else begin
      case (addr)
        `OFS_CONTROL:    rdata_r <= DATA_W'(ctrl_r);
        `OFS_PRESCALE:   rdata_r <= DATA_W'(prescale_r);
        `OFS_FIRST_CNT:  rdata_r <= DATA_W'(cnt1_r);
        `OFS_SECOND_CNT: rdata_r <= DATA_W'(cnt2_r);
        `OFS_HOLD_A:     rdata_r <= DATA_W'(hold_a_r);
        `OFS_HOLD_B:     rdata_r <= DATA_W'(hold_b_r);
        `OFS_IRQ_ENABLE: rdata_r <= DATA_W'(ien_r);
        `OFS_PENDING:    rdata_r <= DATA_W'(pend_r);
        `OFS_PIN_SELECT: rdata_r <= sel_r;
        default:         rdata_r <= '0;
      endcase
    end
  end

  assign rdata           = rdata_r;
  assign timer_pin_a_out = pwm_r;
  assign timer_pin_a_oe  = pwm_oe_r;
  // interrupt lines; counter two underflow only when enabled
  assign irq_first  = |(pend_r[`PND_UF1:`PND_A] & ien_r[`PND_UF1:`PND_A]);
  assign irq_second = pend_r[`PND_UF2] && ien_r[`PND_UF2];

  property p_count_down;
    @(posedge sys_clk) disable iff (!rst_n)
    tick1 && (cnt1_r != '0) && !wr_cnt1 && !preset_ev |=> cnt1_r == $past(cnt1_r) - 1'b1;
  endproperty
  a_count_down: assert property (p_count_down)
    else $error("counter one did not count down");

  property p_reload_b;
    @(posedge sys_clk) disable iff (!rst_n)
    pwm_b_ev && !wr_cnt1 |=> (cnt1_r == $past(hold_b_r)) && (phase_r == PH_B);
  endproperty
  a_reload_b: assert property (p_reload_b)
    else $error("second reload not from hold b");

  property p_first_a;
    @(posedge sys_clk) disable iff (!rst_n)
    pwm_a_ev && !wr_cnt1 |=> (cnt1_r == $past(hold_a_r)) && (phase_r == PH_A);
  endproperty
  a_first_a: assert property (p_first_a)
    else $error("reload after restart not from hold a");

  property p_restart_idle;
    @(posedge sys_clk) disable iff (!rst_n)
    pwm_mode && (ckc1 == CKC_NONE) |=> phase_r == PH_IDLE;
  endproperty
  a_restart_idle: assert property (p_restart_idle)
    else $error("no-clock did not reset reload order");

  property p_toggle;
    @(posedge sys_clk) disable iff (!rst_n)
    pwm_b_ev && (pwm_r == start_lvl) |=> timer_pin_a_out != $past(timer_pin_a_out);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pwm pin did not toggle on underflow");

  property p_start_level;
    @(posedge sys_clk) disable iff (!rst_n)
    pwm_a_ev |=> timer_pin_a_out == $past(start_lvl);
  endproperty
  a_start_level: assert property (p_start_level)
    else $error("hold a phase not at start level");

  property p_pend_a;
    @(posedge sys_clk) disable iff (!rst_n)
    reload_a_ev |=> pend_r[`PND_A];
  endproperty
  a_pend_a: assert property (p_pend_a)
    else $error("reload a pending flag lost");

  property p_capture_a;
    @(posedge sys_clk) disable iff (!rst_n)
    cap_a |=> hold_a_r == $past(cnt1_r);
  endproperty
  a_capture_a: assert property (p_capture_a)
    else $error("pin a capture missed");

  property p_uf2_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    uf2 |=> pend_r[`PND_UF2] && (irq_second == ien_r[`PND_UF2]);
  endproperty
  a_uf2_irq: assert property (p_uf2_irq)
    else $error("second counter underflow interrupt wrong");

  property p_dual_reload;
    @(posedge sys_clk) disable iff (!rst_n)
    uf2 && (mode == MODE_DUAL) && !wr_cnt2 |=> cnt2_r == $past(hold_b_r);
  endproperty
  a_dual_reload: assert property (p_dual_reload)
    else $error("mode 3 second counter not reloaded from hold b");
endmodule
`default_nettype wire

//--- mft_cfg.svh
// register map, field positions and reset values of the multifunction timer
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH
`define OFS_CONTROL     8'h00
`define OFS_PRESCALE    8'h04
`define OFS_FIRST_CNT   8'h08
`define OFS_SECOND_CNT  8'h0c
`define OFS_HOLD_A      8'h10
`define OFS_HOLD_B      8'h14
`define OFS_IRQ_ENABLE  8'h18
`define OFS_PENDING     8'h1c
`define OFS_PIN_SELECT  8'h44
`define CTL_MODE_LO     0
`define CTL_MODE_HI     2
`define CTL_ENABLE      3
`define CTL_START_LVL   4
`define CTL_A_RISE      5
`define CTL_B_RISE      6
`define CTL_A_PRESET    7
`define CTL_B_PRESET    8
`define CTL_PULSE_TRAIN 9
`define CTL_CKC1_LO     10
`define CTL_CKC1_HI     12
`define CTL_CKC2_LO     13
`define CTL_CKC2_HI     15
`define CTL_W           16
`define PND_A           0
`define PND_B           1
`define PND_UF1         2
`define PND_UF2         3
`define PND_W           4
`define SEL_FIELD_W     8
`define RST_CTRL        16'h0000
`define RST_PRESCALE    8'h00
`define RST_PIN_SELECT  32'h0000_0000
`endif

//--- mft_pkg.sv
// types shared by the multifunction timer modules
`default_nettype none
package timer_pkg;
  typedef enum logic [2:0] {
    MODE_PWM      = 3'h0,
    MODE_CAPTURE2 = 3'h1,
    MODE_DUAL     = 3'h2,
    MODE_CAPTURE1 = 3'h3
  } mode_t;
  typedef enum logic [2:0] {
    CKC_NONE      = 3'h0,
    CKC_PRESCALE  = 3'h1,
    CKC_EXT_EVENT = 3'h2,
    CKC_PULSE_ACC = 3'h3
  } ckc_t;
  // gray order idle -> lead-in -> a -> b -> a ...
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_LEAD = 2'b01,
    PH_A    = 2'b11,
    PH_B    = 2'b10
  } phase_t;
endpackage
`default_nettype wire

//--- timer_tick_if.sv
// tick and pin event signals passed to the timer core
`timescale 1ns/1ps
`default_nettype none
interface timer_tick_if;
  logic prescale_tick;
  logic a_event;
  logic b_event;
  logic b_level;
  modport prescaler (output prescale_tick);
  modport edges     (output a_event, output b_event, output b_level);
  modport core      (input prescale_tick, input a_event, input b_event, input b_level);
endinterface
`default_nettype wire

//--- clock_prescaler.sv
// programmable divider of the system clock
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler #(
  parameter int PRE_W = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [PRE_W-1:0] divide,
  timer_tick_if.prescaler       tk
);
  logic [PRE_W-1:0] count_r;

  // one tick every divide+1 clocks; restarts while stopped
  // >= so a divide lowered while running never waits for a wrap of the count
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !run) begin
      count_r          <= '0;
      tk.prescale_tick <= 1'b0;
    end else if (count_r >= divide) begin
      count_r          <= '0;
      tk.prescale_tick <= 1'b1;
    end else begin
      count_r          <= count_r + 1'b1;
      tk.prescale_tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- pin_edge_detector.sv
// edge selection for pins a and b
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detector (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic pin_a,
  input  wire logic pin_b,
  input  wire logic a_rise,
  input  wire logic b_rise,
  timer_tick_if.edges ev
);
  logic a_prev_r;
  logic b_prev_r;

  // previous levels; reset loads the live pin so no false edge follows reset
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      a_prev_r <= pin_a;
      b_prev_r <= pin_b;
    end else begin
      a_prev_r <= pin_a;
      b_prev_r <= pin_b;
    end
  end

  // rising or falling edge per pin
  assign ev.a_event = a_rise ? (pin_a && !a_prev_r) : (!pin_a && a_prev_r);
  assign ev.b_event = b_rise ? (pin_b && !b_prev_r) : (!pin_b && b_prev_r);
  assign ev.b_level = pin_b;
endmodule
`default_nettype wire

//--- pin_partner.sv
// pad-side model around the timer: pin a pull-up, pin b and io pads
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  input  wire logic   sys_clk,
  input  wire logic   pwm_level,
  input  wire logic   pwm_oe,
  output logic        pin_a,
  output logic        pin_b,
  output logic [14:0] io
);
  // the timer owns the pad while enabled in mode 1 or 3, otherwise the pull-up wins
  assign pin_a = pwm_oe ? pwm_level : 1'b1;
  initial begin
    pin_b = 1'b0;
    io    = 15'h0000;
  end
  // two-cycle pulse, wider than the one-cycle minimum an event needs
  task automatic pulse_io(input int k);
    @(posedge sys_clk);
    io[k] <= 1'b1;
    repeat (2) @(posedge sys_clk);
    io[k] <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // one rising and one falling edge on pin b
  task automatic pulse_b();
    @(posedge sys_clk);
    pin_b <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pin_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- multifunction_timer_pwm_mode_bench.sv
// self-checking bench for the multifunction timer
`timescale 1ns/1ps
`default_nettype none
`include "mft_cfg.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin $display("[FAIL] %s expected %h seen %h", nm, e, g); err_total++; end end
module multifunction_timer_pwm_mode_bench
  import timer_pkg::*;
;
  localparam logic [31:0] SKIP = 32'hffff_ffff;
  logic        sys_clk, rst_n, wr_strobe, rd_strobe, irq_first, irq_second;
  logic        timer_pin_a_out, timer_pin_a_oe, pin_a, pin_b, rd_seen, last_lvl;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, seed, n;
  logic [15:0] run_len;
  logic [14:0] io;
  logic [31:0] rd_q[$];
  logic [31:0] pwm_q[$];
  int          err_total, samples_checked, i;

  multifunction_timer u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rdata(rdata), .io_in(io),
    .timer_pin_a_in(pin_a), .timer_pin_a_out(timer_pin_a_out),
    .timer_pin_a_oe(timer_pin_a_oe), .timer_pin_b_in(pin_b), .irq_first(irq_first),
    .irq_second(irq_second));
  pin_partner u_pins (.sys_clk(sys_clk), .pwm_level(timer_pin_a_out),
    .pwm_oe(timer_pin_a_oe), .pin_a(pin_a), .pin_b(pin_b), .io(io));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] ctl(logic [2:0] m, logic en, logic s, logic [2:0] c1,
                                      logic [2:0] c2);
    ctl = 32'h0000_0060;
    ctl[2:0] = m;
    ctl[3] = en;
    ctl[4] = s;
    ctl[12:10] = c1;
    ctl[15:13] = c2;
  endfunction

  function automatic void next();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c1_1db7 : 32'h0);
  endfunction

  task automatic report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // register port: one-cycle strobes, every change right after a rising edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr      <= a;
    wdata     <= d;
    wr_strobe <= 1'b1;
    @(posedge sys_clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge sys_clk);
    addr      <= a;
    rd_strobe <= 1'b1;
    @(posedge sys_clk);
    rd_strobe <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so compare there
  always @(posedge sys_clk) begin
    if (rd_seen) begin
      n = rd_q.pop_front();
      `CHK("rdata", n, rdata);
    end
    rd_seen <= rd_strobe;
  end

  // phase length monitor: each toggle closes a phase, compared with the oldest note
  always @(posedge sys_clk) begin
    if (rst_n && timer_pin_a_out !== last_lvl) begin
      if (pwm_q.size() > 0) begin
        n = pwm_q.pop_front();
        if (n !== SKIP) `CHK("pwm phase", n, {15'h0, last_lvl, run_len});
      end
      run_len <= 16'h1;
    end else run_len <= run_len + 16'h1;
    last_lvl <= timer_pin_a_out;
  end

  task automatic drain();
    for (int k = 0; k < 4000 && pwm_q.size() > 0; k++) @(posedge sys_clk);
    if (pwm_q.size() > 0) begin
      err_total++;
      report_and_stop();
    end
  endtask

  // pwm run: start from disable, then restart after the no-clock setting
  task automatic run_pwm(input logic s, input logic [7:0] p, input logic [15:0] ha,
                         input logic [15:0] hb);
    logic [15:0] la, lb;
    la = (ha + 16'h1) * ({8'h0, p} + 16'h1);
    lb = (hb + 16'h1) * ({8'h0, p} + 16'h1);
    wr(`OFS_CONTROL, ctl(MODE_PWM, 1'b0, s, 3'h1, 3'h0));
    wr(`OFS_PRESCALE, {24'h0, p});
    wr(`OFS_FIRST_CNT, 32'h1);
    wr(`OFS_HOLD_A, {16'h0, ha});
    wr(`OFS_HOLD_B, {16'h0, hb});
    wr(`OFS_IRQ_ENABLE, 32'h3);
    for (int r = 0; r < 2; r++) begin
      pwm_q.push_back(SKIP);
      pwm_q.push_back({15'h0, s, la});
      pwm_q.push_back({15'h0, ~s, lb});
      pwm_q.push_back({15'h0, s, la});
      wr(`OFS_CONTROL, ctl(MODE_PWM, 1'b1, s, 3'h1, 3'h0));
      drain();
      `CHK("pin_oe", 1'b1, timer_pin_a_oe);
      // stop inside the b phase so the restart shows no extra toggle
      wr(`OFS_CONTROL, ctl(MODE_PWM, 1'b1, s, 3'h0, 3'h0));
      repeat (6) @(posedge sys_clk);
    end
    `CHK("irq_first", 1'b1, irq_first);
    rd(`OFS_PENDING, 32'h3);
    wr(`OFS_PENDING, 32'h3);
    rd(`OFS_PENDING, 32'h0);
    `CHK("irq_first", 1'b0, irq_first);
  endtask

  // capture with a stopped counter so the captured value is known exactly
  task automatic capture(input logic [2:0] m);
    logic [7:0] ka, kb;
    next();
    ka = seed[23:16] % 8'h0f;
    kb = seed[31:24] % 8'h0f;
    wr(`OFS_CONTROL, ctl(m, 1'b1, 1'b0, 3'h0, 3'h0));
    wr(`OFS_FIRST_CNT, {16'h0, seed[15:0]});
    wr(`OFS_PENDING, 32'hf);
    wr(`OFS_PIN_SELECT, {8'h0e, ka, kb, ka});
    rd(`OFS_PIN_SELECT, {8'h0e, ka, kb, ka});
    if (m == MODE_CAPTURE2) begin
      u_pins.pulse_io(ka);
      rd(`OFS_HOLD_A, {16'h0, seed[15:0]});
    end
    u_pins.pulse_io(kb);
    rd(`OFS_HOLD_B, {16'h0, seed[15:0]});
    rd(`OFS_PENDING, (m == MODE_CAPTURE2) ? 32'h3 : 32'h2);
  endtask

  // watchdog: the whole sequence needs well under this many cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    rst_n = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    wr_strobe = 1'b0;
    rd_strobe = 1'b0;
    rd_seen = 1'b0;
    last_lvl = 1'b1;
    run_len = 16'h0;
    seed = 32'hcc0db869;
    err_total = 0;
    samples_checked = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK("pin_out", 1'b1, timer_pin_a_out);
    `CHK("pin_oe", 1'b0, timer_pin_a_oe);
    for (i = 0; i < 8; i++) rd(8'(i * 4), 32'h0);
    rd(`OFS_PIN_SELECT, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rd(8'h20, 32'h0);
    wr(`OFS_FIRST_CNT, 32'hffff_ffff);
    rd(`OFS_FIRST_CNT, 32'h0000_ffff);
    wr(`OFS_HOLD_A, 32'hffff_ffff);
    rd(`OFS_HOLD_A, 32'h0000_ffff);
    wr(`OFS_PRESCALE, 32'hffff_ffff);
    rd(`OFS_PRESCALE, 32'h0000_00ff);
    for (i = 0; i < 4; i++) begin
      next();
      run_pwm(i[0], (i < 2) ? 8'h00 : {6'h0, seed[1:0]}, {13'h0, seed[4:2]} + 16'h1,
              {13'h0, seed[7:5]} + 16'h4);
    end
    capture(MODE_CAPTURE2);
    capture(MODE_CAPTURE1);
    // second counter as system timer, its interrupt held back until enabled
    wr(`OFS_IRQ_ENABLE, 32'h0);
    wr(`OFS_PRESCALE, 32'h0);
    // mode 3: pin toggles every hold a + 1 ticks, hold b reloads counter two
    next();
    wr(`OFS_FIRST_CNT, 32'h1);
    wr(`OFS_HOLD_A, {29'h0, seed[2:0]} + 32'h1);
    wr(`OFS_HOLD_B, 32'h2);
    pwm_q.push_back(SKIP);
    pwm_q.push_back({16'h0, 13'h0, seed[2:0]} + 32'h2);
    pwm_q.push_back({16'h1, 13'h0, seed[2:0]} + 32'h2);
    wr(`OFS_CONTROL, ctl(MODE_DUAL, 1'b1, 1'b0, 3'h1, 3'h1));
    drain();
    rd(`OFS_PENDING, 32'hb);
    wr(`OFS_CONTROL, ctl(MODE_PWM, 1'b1, 1'b0, 3'h0, 3'h1));
    wr(`OFS_SECOND_CNT, 32'h5);
    wr(`OFS_PENDING, 32'hf);
    repeat (20) @(posedge sys_clk);
    `CHK("irq_second", 1'b0, irq_second);
    rd(`OFS_PENDING, 32'h8);
    wr(`OFS_IRQ_ENABLE, 32'h8);
    @(posedge sys_clk);
    `CHK("irq_second", 1'b1, irq_second);
    // pin b rising edges clock counter two as external events
    wr(`OFS_CONTROL, ctl(MODE_PWM, 1'b1, 1'b0, 3'h0, 3'h2));
    wr(`OFS_SECOND_CNT, 32'h3);
    repeat (2) u_pins.pulse_b();
    rd(`OFS_SECOND_CNT, 32'h1);
    repeat (4) @(posedge sys_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
